// ---- core/abu_map.vh ----
// register map, field positions and reset values of the address breakpoint unit
`ifndef ABU_MAP_VH
`define ABU_MAP_VH
`define ABU_OFF_CTRL 12'h000
`define ABU_OFF_ADDR_HI 12'h004
`define ABU_OFF_ADDR_LO 12'h008
`define ABU_OFF_AUX 12'h00c
`define ABU_OFF_WAIT_STAT 12'h010
`define ABU_OFF_FLAG_CTRL 12'h014
`define ABU_OFF_IRQ_STAT 12'h018
`define ABU_OFF_IRQ_CLR 12'h01c
`define ABU_OFF_IRQ_EN 12'h020
`define ABU_BIT_MATCH_EN 7
`define ABU_BIT_ACTIVE 6
`define ABU_BIT_WDOG_HOLD 0
`define ABU_BIT_WAIT_EXIT 1
`define ABU_BIT_FLAG_CLR 7
`define ABU_IRQ_MATCH 0
`define ABU_IRQ_SOFT 1
`define ABU_IRQ_W 2
`define ABU_BYTE_RST 8'h00
`define ABU_IRQ_RST 2'h0
`define ABU_WORD_ZERO 32'h00000000
`endif

// ---- core/abu_breakpoint.v ----
// address breakpoint unit with APB register access and a level interrupt
// What this block does
// (R1) address-match breaks only while match enable bit 7 is set; write 0 or reset clears
// (R2) break-active sets when fetch address equals stored address with matching enabled
// (R3) writing 1 to break-active raises a break without any address match
// (R4) software clears break-active by writing 0 before leaving the routine
// (R5) break address held in high and low byte registers, reset to zero
// (R6) watchdog-hold bit keeps watchdog disabled during a break in monitor mode
// (R7) wait-exit flag reads 1 when a break ended wait mode, else 0
// (R8) software may read wait-exit flag and adjust the stacked return address
// (R9) other modules' flag clearing in break allowed only while clear-enable is 1
// (R10) timer counter halts while a break is in effect
// (R11) the unit stays enabled in wait and stop modes
// (R12) no address-match break while in wait or stop modes
// (R13) a break raises the breakpoint request toward system integration logic
// (R14) a match on an opcode fetch holds off that instruction until service completes
// (R15) a software break is taken just before the next instruction begins
// (R16) clearing active without changing the address gives no new break on that address
// (R17) only fetch addresses compare; request rises in the cycle after the match
// (R18) break-active stays set until written 0 or reset
`timescale 1ns/1ns
`include "abu_map.vh"
`default_nettype none
module abu_breakpoint (
  // clock, reset, enable
  input wire sys_clk_in,
  input wire rst_n_in,
  input wire clk_en_in,
  // apb slave
  input wire psel_in,
  input wire penable_in,
  input wire pwrite_in,
  input wire [11:0] paddr_in,
  input wire [31:0] pwdata_in,
  output reg [31:0] prdata_out,
  output reg pready_out,
  output reg pslverr_out,
  // cpu side
  input wire [15:0] fetch_addr_in,
  input wire fetch_valid_in,
  input wire insn_boundary_in,
  input wire low_power_in,
  input wire monitor_mode_in,
  input wire wait_exit_in,
  input wire break_end_in,
  // system integration side
  output reg breakpoint_request_out,
  output reg watchdog_hold_out,
  output reg timer_halt_out,
  output reg flag_clear_allow_out,
  output reg irq_out
);

  reg match_break_enable_r;
  reg break_active_flag_r;
  reg [7:0] addr_hi_r;
  reg [7:0] addr_lo_r;
  reg watchdog_hold_on_break_r;
  reg wait_exit_by_break_flag_r;
  reg flag_clear_in_break_enable_r;
  reg soft_pend_r;
  reg in_break_r;
  reg rearm_r;
  reg [`ABU_IRQ_W-1:0] irq_stat_r;
  reg [`ABU_IRQ_W-1:0] irq_en_r;
  reg [31:0] rdata_nxt;
  reg [`ABU_IRQ_W-1:0] irq_stat_nxt;

  wire wr_acc = psel_in & penable_in & pwrite_in & ~pready_out;
  wire rd_acc = psel_in & penable_in & ~pwrite_in & ~pready_out;
  wire wr_ctrl = wr_acc & (paddr_in == `ABU_OFF_CTRL);
  wire wr_hi = wr_acc & (paddr_in == `ABU_OFF_ADDR_HI);
  wire wr_lo = wr_acc & (paddr_in == `ABU_OFF_ADDR_LO);
  wire wr_aux = wr_acc & (paddr_in == `ABU_OFF_AUX);
  wire wr_flag = wr_acc & (paddr_in == `ABU_OFF_FLAG_CTRL);
  wire wr_irq_en = wr_acc & (paddr_in == `ABU_OFF_IRQ_EN);
  wire [15:0] brk_addr = {addr_hi_r, addr_lo_r};

  // match only on fetches, not in low power, only when armed
  wire addr_hit = match_break_enable_r & fetch_valid_in & ~low_power_in & rearm_r & // R1 R12 R17
                  (fetch_addr_in == brk_addr); // R2
  wire soft_set = wr_ctrl & pwdata_in[`ABU_BIT_ACTIVE]; // R3
  wire soft_take = soft_pend_r & insn_boundary_in; // R15
  wire brk_evt = addr_hit | soft_take; // R13
  // break state as the rest of the chip sees it, ending with the service return
  wire break_on = brk_evt | (in_break_r & ~break_end_in);

  reg [`ABU_IRQ_W-1:0] ev;
  always @* begin
    ev = {soft_take, addr_hit};
  end

  genvar gi;
  generate
    for (gi = 0; gi < `ABU_IRQ_W; gi = gi + 1) begin : g_irq
      // set wins over clear
      always @* begin
        irq_stat_nxt[gi] = ev[gi] | (irq_stat_r[gi] &
          ~(wr_acc && paddr_in == `ABU_OFF_IRQ_CLR && pwdata_in[gi]));
      end
    end
  endgenerate

  always @* begin
    rdata_nxt = `ABU_WORD_ZERO;
    case (paddr_in)
      `ABU_OFF_CTRL: begin
        rdata_nxt[`ABU_BIT_MATCH_EN] = match_break_enable_r;
        rdata_nxt[`ABU_BIT_ACTIVE] = break_active_flag_r;
      end
      `ABU_OFF_ADDR_HI: begin
        rdata_nxt[7:0] = addr_hi_r;
      end
      `ABU_OFF_ADDR_LO: begin
        rdata_nxt[7:0] = addr_lo_r;
      end
      `ABU_OFF_AUX: begin
        rdata_nxt[`ABU_BIT_WDOG_HOLD] = watchdog_hold_on_break_r;
      end
      `ABU_OFF_WAIT_STAT: begin
        rdata_nxt[`ABU_BIT_WAIT_EXIT] = wait_exit_by_break_flag_r; // R7
      end
      `ABU_OFF_FLAG_CTRL: begin
        rdata_nxt[`ABU_BIT_FLAG_CLR] = flag_clear_in_break_enable_r;
      end
      `ABU_OFF_IRQ_STAT: begin
        rdata_nxt[`ABU_IRQ_W-1:0] = irq_stat_r;
      end
      `ABU_OFF_IRQ_EN: begin
        rdata_nxt[`ABU_IRQ_W-1:0] = irq_en_r;
      end
      default: rdata_nxt = `ABU_WORD_ZERO;
    endcase
  end

  wire known = (paddr_in == `ABU_OFF_CTRL) |
               (paddr_in == `ABU_OFF_ADDR_HI) |
               (paddr_in == `ABU_OFF_ADDR_LO) |
               (paddr_in == `ABU_OFF_AUX) |
               (paddr_in == `ABU_OFF_WAIT_STAT) |
               (paddr_in == `ABU_OFF_FLAG_CTRL) |
               (paddr_in == `ABU_OFF_IRQ_STAT) |
               (paddr_in == `ABU_OFF_IRQ_CLR) |
               (paddr_in == `ABU_OFF_IRQ_EN);

  // ready answers the first access cycle only, giving one wait state
  always @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      pready_out <= 1'b0;
    end else if (clk_en_in) begin
      pready_out <= psel_in & penable_in & ~pready_out;
    end
  end

  // unmapped offsets answer with an error and read as zero
  always @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      pslverr_out <= 1'b0;
    end else if (clk_en_in) begin
      pslverr_out <= psel_in & penable_in & ~pready_out & ~known;
    end
  end

  // read data stands until the next read
  always @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      prdata_out <= `ABU_WORD_ZERO;
    end else if (clk_en_in && rd_acc) begin
      prdata_out <= rdata_nxt;
    end
  end

  // the unit keeps running through wait and stop; only the clock enable freezes it
  always @(posedge sys_clk_in) begin // R11
    if (!rst_n_in) begin
      match_break_enable_r <= 1'b0;
    end else if (clk_en_in && wr_ctrl) begin
      match_break_enable_r <= pwdata_in[`ABU_BIT_MATCH_EN]; // R1
    end
  end

  // breakpoint address, high byte and low byte
  always @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      addr_hi_r <= `ABU_BYTE_RST;
    end else if (clk_en_in && wr_hi) begin
      addr_hi_r <= pwdata_in[7:0]; // R5
    end
  end

  always @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      addr_lo_r <= `ABU_BYTE_RST;
    end else if (clk_en_in && wr_lo) begin
      addr_lo_r <= pwdata_in[7:0]; // R5
    end
  end

  always @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      watchdog_hold_on_break_r <= 1'b0;
    end else if (clk_en_in && wr_aux) begin
      watchdog_hold_on_break_r <= pwdata_in[`ABU_BIT_WDOG_HOLD]; // R6
    end
  end

  always @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      flag_clear_in_break_enable_r <= 1'b0;
    end else if (clk_en_in && wr_flag) begin
      flag_clear_in_break_enable_r <= pwdata_in[`ABU_BIT_FLAG_CLR]; // R9
    end
  end

  // hardware set wins over a software clear in the same cycle
  always @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      break_active_flag_r <= 1'b0;
    end else if (clk_en_in) begin
      if (brk_evt || soft_set) begin
        break_active_flag_r <= 1'b1; // R2 R18
      end else if (wr_ctrl && !pwdata_in[`ABU_BIT_ACTIVE]) begin
        break_active_flag_r <= 1'b0;
      end
    end
  end

  // a software break waits for the next instruction boundary
  always @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      soft_pend_r <= 1'b0;
    end else if (clk_en_in) begin
      if (soft_take) begin
        soft_pend_r <= 1'b0;
      end else if (soft_set) begin
        soft_pend_r <= 1'b1; // R15
      end
    end
  end

  // disarm after a hit until the high or low address register is written
  always @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      rearm_r <= 1'b1;
    end else if (clk_en_in) begin
      if (addr_hit) begin
        rearm_r <= 1'b0; // R16
      end else if (wr_hi || wr_lo) begin
        rearm_r <= 1'b1;
      end
    end
  end

  // break state lasts until the service return
  always @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      in_break_r <= 1'b0;
    end else if (clk_en_in) begin
      if (brk_evt) begin
        in_break_r <= 1'b1; // R14
      end else if (break_end_in) begin
        in_break_r <= 1'b0;
      end
    end
  end

  // wait-exit cause is kept for the service routine and dropped on its return
  always @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      wait_exit_by_break_flag_r <= 1'b0;
    end else if (clk_en_in) begin
      if (brk_evt && wait_exit_in) begin
        wait_exit_by_break_flag_r <= 1'b1; // R7
      end else if (break_end_in) begin
        wait_exit_by_break_flag_r <= 1'b0;
      end
    end
  end

  // request and timer halt rise one cycle after the event and drop after the return
  always @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      breakpoint_request_out <= 1'b0;
    end else if (clk_en_in) begin
      breakpoint_request_out <= break_on; // R13 R14 R17
    end
  end

  always @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      timer_halt_out <= 1'b0;
    end else if (clk_en_in) begin
      timer_halt_out <= break_on; // R10
    end
  end

  always @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      watchdog_hold_out <= 1'b0;
    end else if (clk_en_in) begin
      watchdog_hold_out <= watchdog_hold_on_break_r & monitor_mode_in & break_on; // R6
    end
  end

  // other modules may clear flags outside a break, or inside one when allowed
  always @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      flag_clear_allow_out <= 1'b0;
    end else if (clk_en_in) begin
      flag_clear_allow_out <= flag_clear_in_break_enable_r | ~(brk_evt | in_break_r); // R9
    end
  end

  // status takes the set-wins next value from the per-bit logic
  always @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      irq_stat_r <= `ABU_IRQ_RST;
    end else if (clk_en_in) begin
      irq_stat_r <= irq_stat_nxt;
    end
  end

  always @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      irq_en_r <= `ABU_IRQ_RST;
    end else if (clk_en_in && wr_irq_en) begin
      irq_en_r <= pwdata_in[`ABU_IRQ_W-1:0];
    end
  end

  // level interrupt follows the next status so it rises with the status bit
  always @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      irq_out <= 1'b0;
    end else if (clk_en_in) begin
      irq_out <= |(irq_stat_nxt & irq_en_r);
    end
  end

endmodule
`default_nettype wire

// ---- verification/abu_breakpoint_chk.sv ----
// port assertions for the address breakpoint unit
`timescale 1ns/1ns
`default_nettype none
module abu_breakpoint_chk (
  input wire logic sys_clk_in, rst_n_in, psel_in, penable_in, fetch_valid_in, low_power_in,
  input wire logic insn_boundary_in, monitor_mode_in, break_end_in, pready_out, pslverr_out,
  input wire logic breakpoint_request_out, watchdog_hold_out, timer_halt_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  a_ready_pulse: assert property (pready_out |=> !pready_out) else $error("ready too long");
  a_ready_access: assert property (pready_out |-> $past(psel_in && penable_in)) else $error("ready unasked");
  a_err_ready: assert property (pslverr_out |-> pready_out) else $error("error without ready");
  a_halt_req: assert property (timer_halt_out == breakpoint_request_out) else $error("timer runs");
  a_req_stands: assert property (breakpoint_request_out && !break_end_in |=> breakpoint_request_out)
    else $error("request dropped");
  a_req_ends: assert property (breakpoint_request_out && break_end_in |=> !breakpoint_request_out)
    else $error("request stuck");
  a_req_cause: assert property ($rose(breakpoint_request_out) |->
    $past(fetch_valid_in && !low_power_in || insn_boundary_in)) else $error("request without cause");
  a_wdog_break: assert property (watchdog_hold_out |-> $past(monitor_mode_in) &&
    (breakpoint_request_out || $past(breakpoint_request_out))) else $error("hold outside break");
  c_break: cover property ($rose(breakpoint_request_out));
  c_hold: cover property (watchdog_hold_out);
  c_err: cover property (pslverr_out);
endmodule
bind abu_breakpoint abu_breakpoint_chk u_abu_breakpoint_chk (.*);
`default_nettype wire

// ---- verification/abu_cpu_model.sv ----
// cpu and system integration model: fetches and ends breaks
`timescale 1ns/1ns
`default_nettype none
module abu_cpu_model (
  input wire logic clk_in, rst_n_in, run_in, req_in,
  input wire logic [7:0] lat_in,
  output logic [15:0] addr_out,
  output logic fetch_out, end_out
);
  logic [15:0] pc_r;
  logic [7:0] cnt_r;
  // no fetch while a break is pending service
  assign fetch_out = run_in && !req_in;
  // idle bus shows no stale address
  assign addr_out = fetch_out ? pc_r : ~pc_r;
  assign end_out = req_in && cnt_r == lat_in;
  always_ff @(posedge clk_in) begin
    pc_r <= !rst_n_in ? 16'h0000 : pc_r + 16'(fetch_out);
    cnt_r <= req_in && !end_out ? cnt_r + 8'h01 : 8'h00;
  end
endmodule
`default_nettype wire

// ---- verification/tb_abu_breakpoint.sv ----
// self-checking bench for the address breakpoint unit
`timescale 1ns/1ns
`default_nettype none
module tb_abu_breakpoint;
  logic sys_clk_in = 1'h0, rst_n_in = 1'h0, clk_en_in = 1'h1, psel_in = 1'h0, penable_in = 1'h0;
  logic pwrite_in = 1'h0, low_power_in = 1'h0, monitor_mode_in = 1'h1, wait_exit_in = 1'h0, run = 1'h0;
  logic [11:0] paddr_in = 12'h0;
  logic [31:0] pwdata_in = 32'h0, prdata_out, rd_q;
  logic [15:0] fetch_addr_in;
  logic [7:0] lat = 8'h3c;
  logic pready_out, pslverr_out, fetch_valid_in, insn_boundary_in, break_end_in, breakpoint_request_out;
  logic watchdog_hold_out, timer_halt_out, flag_clear_allow_out, irq_out, err_q, hit;
  int err_total = 0, n_checks = 0;
  assign insn_boundary_in = fetch_valid_in;
  abu_breakpoint u_abu_breakpoint (.*);
  abu_cpu_model u_abu_cpu_model (.clk_in(sys_clk_in), .rst_n_in(rst_n_in), .run_in(run),
    .req_in(breakpoint_request_out), .lat_in(lat), .addr_out(fetch_addr_in), .fetch_out(fetch_valid_in),
    .end_out(break_end_in));
  initial forever #4 sys_clk_in = ~sys_clk_in;
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge sys_clk_in);
    {psel_in, pwrite_in, paddr_in, pwdata_in} <= {1'h1, w, a, d};
    @(posedge sys_clk_in);
    penable_in <= 1'h1;
    i = 0;
    do begin @(negedge sys_clk_in); i++; end while (pready_out !== 1'h1 && i < 20);
    rd_q = prdata_out;
    err_q = pslverr_out;
    @(posedge sys_clk_in);
    if (i == 20) begin err_total++; stop_test(); end
    {psel_in, penable_in} <= 2'h0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    xfer(1'h0, a, 32'h0);
    chk(rd_q, e);
  endtask
  task automatic wt(input int n, input logic want);
    for (int i = 0; i < n && breakpoint_request_out !== want; i++) @(negedge sys_clk_in);
    chk(breakpoint_request_out, want);
  endtask
  task automatic arm;
    logic [15:0] t;
    t = fetch_addr_in + 16'h0020;
    xfer(1'h1, 12'h004, {24'h0, t[15:8]});
    xfer(1'h1, 12'h008, {24'h0, t[7:0]});
  endtask
  initial begin
    repeat (2) @(posedge sys_clk_in);
    rst_n_in <= 1'h1;
    for (int k = 0; k < 9; k++) if (k != 7) rd(12'(4 * k), 32'h0);
    rd(12'h100, 32'h0);
    chk(err_q, 1'h1);
    xfer(1'h1, 12'h020, 32'h3);
    xfer(1'h1, 12'h00c, 32'h1);
    run <= 1'h1;
    arm();
    xfer(1'h1, 12'h000, 32'h80);
    wt(60, 1'h1);
    @(negedge sys_clk_in);
    chk({timer_halt_out, watchdog_hold_out, flag_clear_allow_out, irq_out}, 4'hd);
    rd(12'h000, 32'hc0);
    rd(12'h018, 32'h1);
    wt(80, 1'h0);
    rd(12'h000, 32'hc0);
    xfer(1'h1, 12'h000, 32'h80);
    rd(12'h000, 32'h80);
    xfer(1'h1, 12'h01c, 32'h3);
    rd(12'h018, 32'h0);
    chk(irq_out, 1'h0);
    xfer(1'h1, 12'h014, 32'h80);
    xfer(1'h1, 12'h020, 32'h2);
    wait_exit_in <= 1'h1;
    xfer(1'h1, 12'h000, 32'h40);
    wt(20, 1'h1);
    @(negedge sys_clk_in);
    chk({flag_clear_allow_out, irq_out}, 2'h3);
    rd(12'h010, 32'h2);
    rd(12'h018, 32'h2);
    xfer(1'h1, 12'h020, 32'h0);
    rd(12'h018, 32'h2);
    chk(irq_out, 1'h0);
    wt(80, 1'h0);
    rd(12'h010, 32'h0);
    {wait_exit_in, lat} <= 9'h001;
    for (int k = 0; k < 3; k++) begin
      low_power_in <= k == 0;
      xfer(1'h1, 12'h000, k == 2 ? 32'h0 : 32'h80);
      arm();
      hit = 1'h0;
      repeat (60) @(negedge sys_clk_in) hit |= breakpoint_request_out;
      chk(hit, k == 1);
      wt(20, 1'h0);
    end
    stop_test();
  end
endmodule
`default_nettype wire
